// ==== hdl/return_stack_params.svh ====
// Register offsets, field positions and reset values of the return stack.
// Included by the stack module; holds definitions only.
`ifndef RETURN_STACK_PARAMS_SVH
`define RETURN_STACK_PARAMS_SVH
`define RS_ADDR_W        3
`define RS_OFF_TOP_LOW   3'h0
`define RS_OFF_TOP_HIGH  3'h1
`define RS_OFF_PTR       3'h2
`define RS_OFF_STATUS    3'h3
`define RS_OFF_MASK      3'h4
`define RS_OFF_CFG       3'h5
`define RS_BIT_OVF       0
`define RS_BIT_UNF       1
`define RS_STATUS_RST    8'h00
`define RS_MASK_RST      8'h00
`endif

// ==== hdl/return_stack_pkg.sv ====
// Types shared by the return stack design.
// Assumes the core issues at most one stack action per cycle.
package return_stack_pkg;
    typedef enum logic [1:0] {
        OP_IDLE = 2'b00,
        OP_PUSH = 2'b01,
        OP_POP  = 2'b10
    } stack_op_t;
endpackage

// ==== hdl/hardware_return_stack.sv ====
// Hardware return-address stack with software access registers.
// Assumes push and pop come from core logic on ref_clk; the error reset
// enable strap comes from outside and is synchronised here.
//
// The address map and strobed register access are this design's own decisions.
`include "return_stack_params.svh"

module hardware_return_stack #(
    parameter int DEPTH = 16,           // Stack entries
    parameter int PC_W  = 15            // Program counter width
) (
    input  wire logic                 ref_clk,      // Core clock
    input  wire logic                 arst_n,       // Async reset
    input  wire logic                 dev_reset,    // Core reset pulse
    input  wire logic                 err_rst_pin,  // Error reset strap
    input  wire logic                 push_req,     // Call or int entry
    input  wire logic [PC_W-1:0]      push_pc,      // PC to save
    input  wire logic                 pop_req,      // Any return
    output logic      [PC_W-1:0]      ret_pc,       // Popped PC
    output logic                      ret_valid,    // Popped PC valid
    output logic                      stack_rst,    // Device reset pulse
    output logic                      irq,          // Interrupt level
    input  wire logic [`RS_ADDR_W-1:0] addr,        // Register address
    input  wire logic [7:0]           wdata,        // Write data
    input  wire logic                 wr,           // Write strobe
    input  wire logic                 rd,           // Read strobe
    output logic      [7:0]           rdata         // Read data
);
    import return_stack_pkg::*;

    localparam int IDX_W = $clog2(DEPTH);
    localparam int PTR_W = IDX_W + 1;
    localparam int HI_W  = PC_W - 8;

    // Pointer value for an empty stack; first push lands on entry 0
    localparam logic [PTR_W-1:0] PTR_EMPTY = '1;
    localparam logic [PTR_W-1:0] PTR_TOP =
        PTR_W'(DEPTH - 1);
    localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

    if ((DEPTH < 2) || ((DEPTH & (DEPTH - 1)) != 0)) begin : g_chk_d
        $error("DEPTH must be a power of two");
    end
    if ((PC_W < 9) || (PC_W > 16)) begin : g_chk_w
        $error("PC_W must lie between 9 and 16");
    end

    typedef struct packed {
        logic [DEPTH-1:0][PC_W-1:0] mem;
        logic [PTR_W-1:0]           ptr;
        logic [7:0]                 status;
        logic [7:0]                 mask;
        logic [7:0]                 rdata;
        logic [PC_W-1:0]            ret_pc;
        logic                       ret_valid;
        logic                       stack_rst;
        logic                       irq;
        logic                       cfg_s1;
        logic                       cfg_s2;
    } st_t;

    localparam st_t ST_RST = '{
        mem:       '0,
        ptr:       PTR_EMPTY,
        status:    `RS_STATUS_RST,
        mask:      `RS_MASK_RST,
        rdata:     8'h00,
        ret_pc:    '0,
        ret_valid: 1'b0,
        stack_rst: 1'b0,
        irq:       1'b0,
        cfg_s1:    1'b0,
        cfg_s2:    1'b0
    };

    st_t st_r;
    st_t st_nxt;

    logic [IDX_W-1:0] idx;
    logic [PC_W-1:0]  top_pc;
    logic             err_rst_en;
    stack_op_t        op;

    assign idx        = st_r.ptr[IDX_W-1:0];
    assign top_pc     = st_r.mem[idx];
    assign err_rst_en = st_r.cfg_s2;

    // Push wins if both arrive; the pop is dropped
    always_comb begin
        if (push_req) begin
            op = OP_PUSH;
        end else if (pop_req) begin
            op = OP_POP;
        end else begin
            op = OP_IDLE;
        end
    end

    always_comb begin
        logic [PTR_W-1:0] ptr_up;
        logic             ovf;
        logic             unf;
        logic             rd_status;
        ptr_up    = st_r.ptr + PTR_ONE;
        ovf       = 1'b0;
        unf       = 1'b0;
        rd_status = rd && (addr == `RS_OFF_STATUS);
        st_nxt    = st_r;
        st_nxt.ret_valid = 1'b0;
        st_nxt.stack_rst = 1'b0;
        st_nxt.rdata     = 8'h00;
        st_nxt.cfg_s1    = err_rst_pin;
        st_nxt.cfg_s2    = st_r.cfg_s1;

        // Software side first, so a same-cycle push or pop overrides it
        if (wr) begin
            case (addr)
                `RS_OFF_TOP_LOW: begin
                    st_nxt.mem[idx][7:0] = wdata;
                end
                `RS_OFF_TOP_HIGH: begin
                    st_nxt.mem[idx][PC_W-1:8] = wdata[HI_W-1:0];
                end
                `RS_OFF_PTR: begin
                    st_nxt.ptr = wdata[PTR_W-1:0];
                end
                `RS_OFF_MASK: begin
                    st_nxt.mask = wdata;
                end
                default: begin
                end
            endcase
        end

        // Stack entries, pointer, the popped PC latch and the reset pulse change here
        case (op)
            OP_PUSH: begin
                ovf = (st_r.ptr == PTR_TOP);
                if (ovf && err_rst_en) begin
                    st_nxt.stack_rst = 1'b1;
                end else begin
                    // Wrap of the index reuses the oldest entry
                    st_nxt.ptr = ptr_up;
                    st_nxt.mem[ptr_up[IDX_W-1:0]] = push_pc;
                end
            end
            OP_POP: begin
                unf = (st_r.ptr == PTR_EMPTY);
                st_nxt.ret_pc    = top_pc;
                st_nxt.ret_valid = 1'b1;
                if (unf && err_rst_en) begin
                    st_nxt.stack_rst = 1'b1;
                end else begin
                    st_nxt.ptr = st_r.ptr - PTR_ONE;
                end
            end
            default: begin
            end
        endcase

        // Reset cause must survive the reset it triggers
        if (st_nxt.stack_rst || dev_reset) begin
            st_nxt.ptr = PTR_EMPTY;
        end

        // Read clears, but a new event in the same cycle stays set
        if (rd_status) begin
            st_nxt.status = 8'h00;
        end
        if (ovf) begin
            st_nxt.status[`RS_BIT_OVF] = 1'b1;
        end
        if (unf) begin
            st_nxt.status[`RS_BIT_UNF] = 1'b1;
        end
        st_nxt.irq = |(st_nxt.status & st_nxt.mask);

        if (rd) begin
            case (addr)
                `RS_OFF_TOP_LOW: begin
                    st_nxt.rdata = top_pc[7:0];
                end
                `RS_OFF_TOP_HIGH: begin
                    st_nxt.rdata = 8'(top_pc[PC_W-1:8]);
                end
                `RS_OFF_PTR: begin
                    st_nxt.rdata = 8'(st_r.ptr);
                end
                `RS_OFF_STATUS: begin
                    st_nxt.rdata = st_r.status;
                end
                `RS_OFF_MASK: begin
                    st_nxt.rdata = st_r.mask;
                end
                `RS_OFF_CFG: begin
                    st_nxt.rdata = {7'h00, err_rst_en};
                end
                default: begin
                    st_nxt.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ret_pc    = st_r.ret_pc;
    assign ret_valid = st_r.ret_valid;
    assign stack_rst = st_r.stack_rst;
    assign irq       = st_r.irq;
    assign rdata     = st_r.rdata;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    a_push_ptr_step: assert property (
        push_req && !dev_reset && !(st_r.ptr == PTR_TOP && err_rst_en)
        |=> st_r.ptr == PTR_W'($past(st_r.ptr) + PTR_ONE)
    ) else $error("push did not step pointer up");

    a_push_stores_pc: assert property (
        push_req && !dev_reset && !(st_r.ptr == PTR_TOP && err_rst_en)
        |=> top_pc == $past(push_pc)
    ) else $error("pushed PC not at new top");

    a_pop_returns_top: assert property (
        pop_req && !push_req
        |=> ret_valid && ret_pc == $past(top_pc)
    ) else $error("pop did not return old top");

    a_pop_ptr_step: assert property (
        pop_req && !push_req && !dev_reset
        && !(st_r.ptr == PTR_EMPTY && err_rst_en)
        |=> st_r.ptr == PTR_W'($past(st_r.ptr) - PTR_ONE)
    ) else $error("pop did not step pointer down");

    a_ovf_flag_set: assert property (
        push_req && st_r.ptr == PTR_TOP
        |=> st_r.status[`RS_BIT_OVF] ##0 irq == |(st_r.status & st_r.mask)
    ) else $error("overflow flag missing");

    a_unf_flag_set: assert property (
        pop_req && !push_req && st_r.ptr == PTR_EMPTY
        |=> st_r.status[`RS_BIT_UNF]
    ) else $error("underflow flag missing");

    a_err_reset_fire: assert property (
        ((push_req && st_r.ptr == PTR_TOP)
         || (pop_req && !push_req && st_r.ptr == PTR_EMPTY)) && err_rst_en
        |=> stack_rst && st_r.ptr == PTR_EMPTY
            ##1 (!stack_rst || $past(push_req || pop_req))
    ) else $error("stack error reset not issued");

    a_circ_no_reset: assert property (
        !err_rst_en && !$past(err_rst_en) |-> !stack_rst
    ) else $error("reset issued in circular mode");

    a_dev_reset_empty: assert property (
        dev_reset |=> st_r.ptr == PTR_EMPTY
    ) else $error("pointer not empty after reset");

endmodule

// ==== verif/core_seq_model.sv ====
// Core sequencer model: issues pushes and pops to the return stack.
// Assumes the bench calls one task at a time, just after a clock edge.
module core_seq_model (
    input  wire logic        ref_clk,   // Core clock
    output logic             push_req,  // Call or int entry
    output logic [14:0]      push_pc,   // PC to save
    output logic             pop_req    // Any return
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        push_req = 1'b0;
        pop_req  = 1'b0;
        push_pc  = 15'h0000;
    end
    task automatic do_push(input logic [14:0] pc);
        @(posedge ref_clk);
        push_req <= 1'b1;
        push_pc  <= pc;
        @(posedge ref_clk);
        push_req <= 1'b0;
        push_pc  <= ~pc;  // Stale value would hide a late sample
    endtask
    task automatic do_push_pop(input logic [14:0] pc);
        @(posedge ref_clk);
        push_req <= 1'b1;
        pop_req  <= 1'b1;
        push_pc  <= pc;
        @(posedge ref_clk);
        push_req <= 1'b0;
        pop_req  <= 1'b0;
        push_pc  <= ~pc;
    endtask
    task automatic do_pop();
        @(posedge ref_clk);
        pop_req <= 1'b1;
        @(posedge ref_clk);
        pop_req <= 1'b0;
    endtask
endmodule

// ==== verif/hardware_return_stack_tb.sv ====
// Self-checking bench for the return stack; mirror model plus scoreboard.
// Assumes the default sixteen entries of fifteen bits.
`include "return_stack_params.svh"
module hardware_return_stack_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, arst_n, dev_reset, err_rst_pin, wr, rd, rd_q;
    logic        push_req, pop_req, ret_valid, stack_rst, irq, strap;
    logic [2:0]  addr;
    logic [7:0]  wdata, rdata, st;
    logic [14:0] push_pc, ret_pc;
    logic [15:0] exp_pc;
    logic [14:0] mem [16];
    logic [4:0]  ptr;
    logic [31:0] seed = 32'h5F96;
    logic [7:0]  q_rd [$];
    logic [14:0] q_pc [$];
    int          err_count, compares, rst_exp, rst_seen;
    core_seq_model core (.ref_clk(ref_clk), .push_req(push_req),
        .push_pc(push_pc), .pop_req(pop_req));
    hardware_return_stack dut (.ref_clk(ref_clk), .arst_n(arst_n),
        .dev_reset(dev_reset), .err_rst_pin(err_rst_pin),
        .push_req(push_req), .push_pc(push_pc), .pop_req(pop_req),
        .ret_pc(ret_pc), .ret_valid(ret_valid), .stack_rst(stack_rst),
        .irq(irq), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr    <= 1'b0;
    endtask
    task automatic reg_rd(input logic [2:0] a, input logic [7:0] e);
        q_rd.push_back(e);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd   <= 1'b0;
        if (a == `RS_OFF_STATUS) st = 8'h00;
    endtask
    task automatic push();
        logic [14:0] pc;
        pc = 15'(xs());
        if (ptr == 5'h0F) st[`RS_BIT_OVF] = 1'b1;
        if (ptr == 5'h0F && strap) begin
            rst_exp++;
            ptr = 5'h1F;
        end else begin
            ptr = ptr + 5'h01;
            mem[ptr[3:0]] = pc;
        end
        core.do_push(pc);
    endtask
    task automatic pop();
        if (ptr == 5'h1F) st[`RS_BIT_UNF] = 1'b1;
        // Every pop answers with the old top, even one that resets
        q_pc.push_back(mem[ptr[3:0]]);
        if (ptr == 5'h1F && strap) rst_exp++;
        else ptr = ptr - 5'h01;
        core.do_pop();
    endtask
    // Push and pop together: the push is taken, the pop dropped
    task automatic push_pop();
        logic [14:0] pc;
        pc = 15'(xs());
        ptr = ptr + 5'h01;
        mem[ptr[3:0]] = pc;
        core.do_push_pop(pc);
    endtask
    task automatic finish_test();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Scoreboard on the falling edge, where outputs have settled
    always @(posedge ref_clk) rd_q <= rd;
    always @(negedge ref_clk) begin
        if (rd_q === 1'b1) check({8'h00, rdata}, {8'h00, q_rd.pop_front()});
        // An answer nobody expected meets FFFF and always mismatches
        if (ret_valid === 1'b1) begin
            exp_pc = (q_pc.size() > 0) ? {1'b0, q_pc.pop_front()} : 16'hFFFF;
            check({1'b0, ret_pc}, exp_pc);
        end
        if (stack_rst === 1'b1) rst_seen++;
    end
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        err_count++;
        finish_test();
    end
    initial begin
        {arst_n, dev_reset, err_rst_pin, wr, rd, strap} = 6'h00;
        addr = 3'h0;
        wdata = 8'h00;
        ptr = 5'h1F;
        st = 8'h00;
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'b1;
        reg_rd(`RS_OFF_PTR, 8'h1F);
        reg_rd(`RS_OFF_MASK, `RS_MASK_RST);
        reg_wr(3'h7, 8'hFF);
        reg_rd(3'h7, 8'h00);
        reg_wr(`RS_OFF_MASK, 8'h03);
        $display("test reset done");
        repeat (16) push();
        reg_rd(`RS_OFF_PTR, 8'h0F);
        push();
        @(negedge ref_clk);
        check(irq, 1'b1);
        reg_rd(`RS_OFF_STATUS, st);
        @(negedge ref_clk);
        check(irq, 1'b0);
        repeat (18) pop();
        reg_rd(`RS_OFF_PTR, {3'h0, ptr});
        reg_rd(`RS_OFF_STATUS, 8'h02);
        $display("test wrap done");
        reg_wr(`RS_OFF_PTR, 8'h05);
        ptr = 5'h05;
        reg_rd(`RS_OFF_TOP_LOW, mem[5][7:0]);
        reg_rd(`RS_OFF_TOP_HIGH, {1'b0, mem[5][14:8]});
        reg_wr(`RS_OFF_TOP_LOW, 8'hA5);
        reg_wr(`RS_OFF_TOP_HIGH, 8'h3C);
        mem[5] = 15'h3CA5;
        pop();
        push_pop();
        reg_rd(`RS_OFF_TOP_LOW, mem[5][7:0]);
        reg_rd(`RS_OFF_PTR, 8'h05);
        reg_wr(`RS_OFF_STATUS, 8'hFF);
        reg_rd(`RS_OFF_STATUS, 8'h00);
        $display("test access done");
        push();
        push();
        @(posedge ref_clk);
        dev_reset <= 1'b1;
        @(posedge ref_clk);
        dev_reset <= 1'b0;
        ptr = 5'h1F;
        reg_rd(`RS_OFF_PTR, 8'h1F);
        reg_rd(`RS_OFF_MASK, 8'h03);
        $display("test core reset done");
        err_rst_pin <= 1'b1;
        strap = 1'b1;
        repeat (3) @(posedge ref_clk);
        reg_rd(`RS_OFF_CFG, 8'h01);
        repeat (17) push();
        reg_rd(`RS_OFF_PTR, 8'h1F);
        reg_rd(`RS_OFF_STATUS, 8'h01);
        pop();
        reg_rd(`RS_OFF_STATUS, 8'h02);
        repeat (4) @(posedge ref_clk);
        check(16'(rst_seen), 16'(rst_exp));
        check(q_pc.size() + q_rd.size(), 0);
        $display("test error reset done");
        finish_test();
    end
endmodule
